// ==== hdl/wdcs_pkg.sv ====
// package: register map, codes and reset values of the watchdog control block
package wdcs_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] WDCS_IDX_CTRL = 12'hFD4; // watchdog_control_register
  localparam logic [11:0] WDCS_IDX_CODE = 12'hFD5; // control_code_register
  localparam logic [11:0] WDCS_IDX_CNT = 12'hFD6; // counter_monitor_register
  localparam logic [11:0] WDCS_IDX_STAT = 12'hFD7; // watchdog_status_register
  localparam int WDCS_AW = 16; // bus address width
  // control register field positions
  localparam int WDCS_CTRL_ACT = 0; // overflow_action_select
  localparam int WDCS_CTRL_WIN = 1; // clear_window_select, 2 bits
  localparam int WDCS_CTRL_PER = 3; // overflow period select, 2 bits
  localparam int WDCS_CTRL_EN = 7; // watchdog_enable_bit
  localparam logic [7:0] WDCS_CTRL_MASK = 8'h9F; // implemented control bits
  localparam logic [7:0] WDCS_CTRL_RST = 8'h80; // enabled, window 00, action irq
  // control codes
  localparam logic [7:0] WDCS_CODE_CLEAR = 8'h4E;
  localparam logic [7:0] WDCS_CODE_DISABLE = 8'hB1;
  // status register
  localparam logic [4:0] WDCS_STAT_HI = 5'h0B; // bits 7..3 read constant
  localparam logic WDCS_RUN_RST = 1'b1; // enabled once warm-up has ended
  localparam logic [7:0] WDCS_CNT_RST = 8'h00;
  localparam logic [7:0] WDCS_CNT_MAX = 8'hFF;
  // window thresholds for selections 01, 10, 11
  localparam logic [7:0] WDCS_WIN1 = 8'h80;
  localparam logic [7:0] WDCS_WIN2 = 8'hC0;
  localparam logic [7:0] WDCS_WIN3 = 8'hE0;
  // clocks per source tick at period select 00
  localparam int WDCS_BASE_DIV = 1024;
  localparam logic [1:0] WDCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] WDCS_RESP_SLVERR = 2'b10;
endpackage

// ==== hdl/wdcs_tick_div.sv ====
// source clock divider: one-cycle tick at a selectable rate
`timescale 1ns/1ps
module wdcs_tick_div #(
  parameter int BASE_DIV = 1024,
  parameter int CW = 24
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [CW-1:0] cnt_q; // cycles since last tick
  logic [CW-1:0] lim; // terminal count for the selected rate

  // each select step slows the tick by four
  always_comb begin
    lim = CW'((BASE_DIV << (2 * sel)) - 1);
  end

  // count only while running, hold otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else if (run) begin
      if (cnt_q >= lim) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign tick = run && (cnt_q >= lim);
endmodule

// ==== hdl/wdcs_top.sv ====
// watchdog control codes, counter readback and status behind an AXI4-Lite slave
//
// How it works
// R1: overflow with action 1 requests reset
// R2: reset request restarts whole chip, warm-up
// R3: clear code zeroes counter, counting continues
// R4: disable code stops watchdog when enable 0
// R5: clear beats simultaneous overflow
// R6: software clears in time and in window
// R7: counter monitor reads live counter value
// R8: run flag shows enabled state
// R9: overflow interrupt sets overflow cause flag
// R10: out-of-window clear sets window cause flag
// R11: status read clears both cause flags
// R12: set beats clear on status read
// R13: action 0 overflow gives nmi, keeps counting
// R14: out-of-window clear raises irq, no clear
// R15: enabled after warm-up; disable zeroes counter
// R16: disable code beats simultaneous overflow
// R17: other codes change nothing
// R18: counter holds in stop, idle, sleep
`timescale 1ns/1ps
module wdcs_top
  import wdcs_pkg::*;
#(
  parameter int BASE_DIV = wdcs_pkg::WDCS_BASE_DIV
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic low_power_hold,
  output logic wdt_reset_req,
  output logic wdt_nmi_req,
  input wire logic [wdcs_pkg::WDCS_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdcs_pkg::WDCS_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import wdcs_pkg::*;

  // word index of a byte address
  function automatic logic [11:0] idx_of(input logic [WDCS_AW-1:0] a);
    return a[13:2];
  endfunction

  logic aw_ok_q; // write address held
  logic w_ok_q; // write data held
  logic [11:0] aw_idx_q; // held write index
  logic [7:0] wdat_q; // held low data byte
  logic wstb_q; // low byte lane enabled
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire; // one-cycle register write
  logic rd_fire; // read address accepted
  logic [11:0] rd_idx; // read index
  logic [7:0] ctrl_q; // watchdog_control_register
  logic run_q; // run_state_flag
  logic [7:0] cnt_q; // 8-bit up counter
  logic ovf_flag_q; // overflow_cause_flag
  logic win_flag_q; // window_violation_cause_flag
  logic rst_req_q;
  logic nmi_q;
  logic tick; // source clock enable
  logic code_wr; // write to control code register
  logic clr_code; // clear code written
  logic dis_code; // disable code written
  logic in_window; // clear permitted now
  logic clr_ok; // accepted clear
  logic clr_bad; // clear outside window
  logic dis_ok; // accepted disable
  logic ovf; // raw overflow
  logic ovf_det; // overflow not masked by code write
  logic stat_rd; // status register read
  logic ctrl_wr; // write to control register

  // ---- bus handshakes ----
  // one write and one read may be in flight at once
  // each ready drops while its half is held, so a second
  // address or data word waits until the write executes
  // the write executes one cycle after both halves are held
  // and the response is raised on that same edge
  // a read is answered on the same edge that takes its address;
  // arready stays low until the read data is accepted
  // only data lane 0 matters: every register is one byte
  assign s_axi_awready = !aw_ok_q;
  assign s_axi_wready = !w_ok_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign wr_fire = aw_ok_q && w_ok_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && !rvalid_q;
  assign rd_idx = idx_of(s_axi_araddr);

  // capture write address and data in either order
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      aw_idx_q <= '0;
      wdat_q <= '0;
      wstb_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_ok_q) begin
        aw_ok_q <= 1'b1;
        aw_idx_q <= idx_of(s_axi_awaddr);
      end else if (wr_fire) begin
        aw_ok_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_ok_q) begin
        w_ok_q <= 1'b1;
        wdat_q <= s_axi_wdata[7:0];
        wstb_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_ok_q <= 1'b0;
      end
    end
  end

  // writes outside the map are answered with an error
  // and change nothing
  // write response, error on unmapped index
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q <= WDCS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (aw_idx_q >= WDCS_IDX_CTRL && aw_idx_q <= WDCS_IDX_STAT) begin
        bresp_q <= WDCS_RESP_OKAY;
      end else begin
        bresp_q <= WDCS_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // reads never change state except the status read, which
  // clears the cause flags in the flag process below
  // read data mux, registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rresp_q <= WDCS_RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= WDCS_RESP_OKAY;
      unique case (rd_idx)
        WDCS_IDX_CTRL: rdata_q <= {24'h000000, ctrl_q};
        WDCS_IDX_CODE: rdata_q <= '0; // write-only
        WDCS_IDX_CNT: rdata_q <= {24'h000000, cnt_q}; // [R7]
        WDCS_IDX_STAT: rdata_q <= {24'h000000, WDCS_STAT_HI, ovf_flag_q, win_flag_q, run_q}; // [R8]
        default: begin
          rdata_q <= '0;
          rresp_q <= WDCS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---- watchdog decode ----
  // priorities inside one cycle, highest first:
  //   accepted disable clears the counter and stops it
  //   accepted clear zeroes the counter
  //   otherwise a source tick advances it
  // an overflow seen together with an accepted clear or any
  // disable code is dropped, so no request and no flag follow
  // a clear outside the window leaves the counter running
  // and raises the interrupt request instead
  // a clear while stopped is ignored altogether
  assign code_wr = wr_fire && wstb_q && (aw_idx_q == WDCS_IDX_CODE);
  assign clr_code = code_wr && (wdat_q == WDCS_CODE_CLEAR);
  assign dis_code = code_wr && (wdat_q == WDCS_CODE_DISABLE);
  assign stat_rd = rd_fire && (rd_idx == WDCS_IDX_STAT);
  assign ctrl_wr = wr_fire && wstb_q && (aw_idx_q == WDCS_IDX_CTRL);

  // a larger selection opens the window later in the count,
  // leaving a shorter span in which a clear is accepted
  // clear window by selection, 00 allows any time
  always_comb begin
    unique case (ctrl_q[WDCS_CTRL_WIN +: 2])
      2'b00: in_window = 1'b1;
      2'b01: in_window = (cnt_q >= WDCS_WIN1);
      2'b10: in_window = (cnt_q >= WDCS_WIN2);
      2'b11: in_window = (cnt_q >= WDCS_WIN3);
    endcase
  end

  assign clr_ok = clr_code && run_q && in_window; // [R3]
  assign clr_bad = clr_code && run_q && !in_window; // [R14]
  assign dis_ok = dis_code && !ctrl_q[WDCS_CTRL_EN]; // [R4]
  assign ovf = run_q && tick && (cnt_q == WDCS_CNT_MAX);
  // a clear or a disable code in the same cycle masks the overflow
  assign ovf_det = ovf && !clr_ok && !dis_code; // [R5] [R16]

  // the divider keeps its phase across clears, so a clear
  // restarts the count but not the tick spacing; the first
  // period after a clear may be up to one tick short
  // holding the divider in low-power modes freezes both
  // source tick, halted in low-power modes
  wdcs_tick_div #(
    .BASE_DIV(BASE_DIV)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .run(run_q && !low_power_hold), // [R18]
    .sel(ctrl_q[WDCS_CTRL_PER +: 2]),
    .tick(tick)
  );

  // control register, enable forced on at reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= WDCS_CTRL_RST; // [R15]
    end else if (ctrl_wr) begin
      ctrl_q <= wdat_q & WDCS_CTRL_MASK;
    end
  end

  // clearing the enable bit alone does not stop the watchdog;
  // it only arms the disable code
  // run state: disable code off, enable bit write on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= WDCS_RUN_RST; // [R15]
    end else if (dis_ok) begin
      run_q <= 1'b0; // [R4] [R8]
    end else if (ctrl_wr && wdat_q[WDCS_CTRL_EN]) begin
      run_q <= 1'b1; // [R8]
    end
  end

  // the counter wraps from its top value back to zero, so an
  // interrupt-mode overflow keeps the watchdog counting
  // up counter; other codes leave it alone
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= WDCS_CNT_RST;
    end else if (dis_ok) begin
      cnt_q <= WDCS_CNT_RST; // [R15]
    end else if (clr_ok) begin
      cnt_q <= WDCS_CNT_RST; // [R3] [R5]
    end else if (run_q && tick) begin
      cnt_q <= cnt_q + 8'h01; // wraps, keeps counting [R13] [R14] [R17]
    end
  end

  // requests are registered so the outputs are glitch free;
  // each lasts exactly one cycle and the receiver must latch it
  // a reset request is left to the system to act on; this
  // block only raises it and keeps counting until reset
  // request pulses: reset or non-maskable interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_req_q <= 1'b0;
      nmi_q <= 1'b0;
    end else begin
      rst_req_q <= ovf_det && ctrl_q[WDCS_CTRL_ACT]; // [R1] [R2]
      nmi_q <= (ovf_det && !ctrl_q[WDCS_CTRL_ACT]) || clr_bad; // [R13] [R14]
    end
  end

  assign wdt_reset_req = rst_req_q;
  assign wdt_nmi_req = nmi_q;

  // flags are read-to-clear; a set in the same cycle as the
  // status read wins so no cause is ever lost, the read then
  // returns the old value and the next read shows the flag
  // a reset-mode overflow leaves no flag behind, since the
  // chip reset that follows clears this block anyway
  // cause flags: set wins over read-clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ovf_flag_q <= 1'b0;
      win_flag_q <= 1'b0;
    end else begin
      if (ovf_det && !ctrl_q[WDCS_CTRL_ACT]) begin
        ovf_flag_q <= 1'b1; // [R9] [R12]
      end else if (stat_rd) begin
        ovf_flag_q <= 1'b0; // [R11]
      end
      if (clr_bad) begin
        win_flag_q <= 1'b1; // [R10] [R12]
      end else if (stat_rd) begin
        win_flag_q <= 1'b0; // [R11]
      end
    end
  end
endmodule

// ==== testbench/wdcs_top_sva.sv ====
// checker: port-level assertions for the watchdog control block
`timescale 1ns/1ps
module wdcs_top_sva #(
  parameter int BASE_DIV = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wdt_reset_req,
  input wire logic wdt_nmi_req,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  // request outputs are single-cycle pulses
  rst_pulse_a: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");
  nmi_pulse_a: assert property (wdt_nmi_req |=> !wdt_nmi_req)
    else $error("interrupt request longer than one cycle");
  // write answer comes two to three cycles after both halves are taken
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // read answer one cycle after the address is taken
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule
bind wdcs_top wdcs_top_sva #(.BASE_DIV(BASE_DIV)) chk (.clk(clk), .rstn(rstn), .wdt_reset_req(wdt_reset_req),
  .wdt_nmi_req(wdt_nmi_req), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ==== testbench/tb.sv ====
// testbench: watchdog control block driven over its register bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
  import wdcs_pkg::*;
  localparam int DIV = 2; // short source tick for simulation
  localparam int OVF_CYC = 256 * DIV; // clocks between overflows at period 00
  logic clk, rstn, hold, rst_req, nmi;
  logic [WDCS_AW-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, wresp;
  logic [7:0] rnd, v;
  int n_mismatch, check_count, cyc, rr_n, nmi_n, nmi_cyc, t0;
  wdcs_top #(.BASE_DIV(DIV)) uut (.clk(clk), .rstn(rstn), .low_power_hold(hold), .wdt_reset_req(rst_req),
    .wdt_nmi_req(nmi), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (rst_req === 1'b1) rr_n++;
    if (nmi === 1'b1) begin
      nmi_n++;
      nmi_cyc = cyc;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected status byte
  function automatic logic [7:0] st(input logic run, input logic win, input logic ovf);
    return {WDCS_STAT_HI, ovf, win, run};
  endfunction
  // write: both halves offered, each released when taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic a, b, da, db;
    da = 1'b0;
    db = 1'b0;
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      a = awready && !da;
      b = wready && !db;
      @(posedge clk);
      if (a) awvalid <= 1'b0;
      if (b) wvalid <= 1'b0;
      da = da || a;
      db = db || b;
    end while (!(da && db));
    do begin
      @(negedge clk);
      a = bvalid;
      wresp = bresp;
      @(posedge clk);
    end while (!a);
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic a;
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      a = arready;
      @(posedge clk);
    end while (!a);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      a = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!a);
    rready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [7:0] e, input string nm);
    rdr(idx, rd, rs);
    `CHK(nm, {24'h0, e}, rd)
  endtask
  // wait for pulse counts to reach a target
  task automatic wait_ev(input int want_rr, input int want_nmi);
    int i;
    for (i = 0; i < 1500 && (rr_n < want_rr || nmi_n < want_nmi); i++) @(negedge clk);
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rstn, hold, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rchk(WDCS_IDX_CTRL, WDCS_CTRL_RST, "ctrl");
    `CHK("rd resp", WDCS_RESP_OKAY, rs)
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "stat");
    rchk(12'h000, 8'h00, "unmapped");
    `CHK("unmapped resp", WDCS_RESP_SLVERR, rs)
    wr(12'h000, 8'hFF);
    `CHK("unmapped wr", WDCS_RESP_SLVERR, wresp)
    wr(WDCS_IDX_CODE, WDCS_CODE_DISABLE);
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "no disable");
    wr(WDCS_IDX_CTRL, 8'h00);
    `CHK("wr resp", WDCS_RESP_OKAY, wresp)
    wr(WDCS_IDX_CODE, WDCS_CODE_DISABLE);
    rchk(WDCS_IDX_STAT, st(0, 0, 0), "disabled");
    rchk(WDCS_IDX_CNT, 8'h00, "cnt zeroed");
    rnd = 8'd73;
    repeat (4) begin
      rnd = lfsr(rnd);
      if (rnd != WDCS_CODE_CLEAR && rnd != WDCS_CODE_DISABLE) wr(WDCS_IDX_CODE, rnd);
    end
    rchk(WDCS_IDX_STAT, st(0, 0, 0), "other codes");
    rchk(WDCS_IDX_CNT, 8'h00, "stopped");
    wr(WDCS_IDX_CTRL, 8'h80);
    repeat (40) @(posedge clk);
    rdr(WDCS_IDX_CNT, rd, rs);
    v = rd[7:0];
    rdr(WDCS_IDX_CNT, rd, rs);
    `CHK("cnt moves", 1'b1, rd[7:0] != v)
    wr(WDCS_IDX_CODE, WDCS_CODE_CLEAR);
    rdr(WDCS_IDX_CNT, rd, rs);
    `CHK("cleared", 1'b1, rd[7:0] < 8'h08)
    hold <= 1'b1;
    rdr(WDCS_IDX_CNT, rd, rs);
    v = rd[7:0];
    repeat (20) @(posedge clk);
    rchk(WDCS_IDX_CNT, v, "held");
    hold <= 1'b0;
    wait_ev(0, 1);
    t0 = nmi_cyc;
    `CHK("ovf nmi", 1, nmi_n)
    rchk(WDCS_IDX_STAT, st(1, 0, 1), "ovf flag");
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "read clear");
    wr(WDCS_IDX_CTRL, 8'h82);
    rdr(WDCS_IDX_CNT, rd, rs);
    v = rd[7:0];
    wr(WDCS_IDX_CODE, WDCS_CODE_CLEAR);
    wait_ev(0, 2);
    `CHK("win nmi", 2, nmi_n)
    rdr(WDCS_IDX_CNT, rd, rs);
    `CHK("not cleared", 1'b1, rd[7:0] > v)
    rchk(WDCS_IDX_STAT, st(1, 1, 0), "win flag");
    // clear executes on the next overflow edge: clear wins
    while (cyc < t0 + OVF_CYC - 4) @(negedge clk);
    wr(WDCS_IDX_CODE, WDCS_CODE_CLEAR);
    repeat (4) @(negedge clk);
    `CHK("clear wins", 2, nmi_n)
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "no ovf flag");
    // disable code with enable set lands on the overflow edge
    while (cyc < t0 + 2 * OVF_CYC - 4) @(negedge clk);
    wr(WDCS_IDX_CODE, WDCS_CODE_DISABLE);
    repeat (4) @(negedge clk);
    `CHK("disable wins", 2, nmi_n)
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "still running");
    // status read taken on the overflow edge: set wins
    while (cyc < t0 + 3 * OVF_CYC - 3) @(negedge clk);
    rdr(WDCS_IDX_STAT, rd, rs);
    `CHK("stat at ovf", {24'h0, st(1, 0, 0)}, rd)
    rchk(WDCS_IDX_STAT, st(1, 0, 1), "set wins");
    `CHK("ovf nmi again", 3, nmi_n)
    wr(WDCS_IDX_CTRL, 8'h81);
    wait_ev(1, 3);
    `CHK("reset req", 1, rr_n)
    `CHK("no nmi", 3, nmi_n)
    rchk(WDCS_IDX_STAT, st(1, 0, 0), "no flag");
    report_and_stop();
  end
endmodule
